// ==== hw/mssm_pkg.sv ====
// Shared constants and types of the motor start and stall monitor
`default_nettype none
package mssm_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS   = 8;
  localparam int TICK_PERIOD_NS  = 100000000;
  localparam int TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [5:0] OFS_CTRL        = 6'h00;
  localparam logic [5:0] OFS_START_TIME  = 6'h04;
  localparam logic [5:0] OFS_STALL_HOT   = 6'h08;
  localparam logic [5:0] OFS_STALL_COLD  = 6'h0C;
  localparam logic [5:0] OFS_START_THR   = 6'h10;
  localparam logic [5:0] OFS_OVERLD_THR  = 6'h14;
  localparam logic [5:0] OFS_NOM_START   = 6'h18;
  localparam logic [5:0] OFS_NOLOAD_THR  = 6'h1C;
  localparam logic [5:0] OFS_STATUS      = 6'h20;
  localparam logic [5:0] OFS_ELAPSED     = 6'h24;
  localparam logic [5:0] OFS_IRQ_STATUS  = 6'h28;
  localparam logic [5:0] OFS_IRQ_MASK    = 6'h2C;
  // ****************************************
  // Control fields
  // ****************************************
  localparam int CTRL_ENABLE     = 0;
  localparam int CTRL_I2T_MODE   = 1;
  localparam int CTRL_AUTO_TIME  = 2;
  localparam int CTRL_SPEED_EN   = 3;
  localparam int CTRL_STALL_EN   = 4;
  localparam int CTRL_FUNC_RESET = 5;
  localparam int CTRL_FORCE_EN   = 7;
  localparam int CTRL_FORCE_LSB  = 8;
  // ****************************************
  // Interrupt bits
  // ****************************************
  localparam int IRQ_START_SEEN  = 0;
  localparam int IRQ_TRIP        = 1;
  localparam int IRQ_STALL_SEEN  = 2;
  localparam int IRQ_START_DONE  = 3;
  localparam int IRQ_BITS        = 4;
  // ****************************************
  // Reset values and response codes
  // ****************************************
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0001;
  localparam logic [15:0] START_TIME_RESET = 16'h0096;
  localparam logic [15:0] STALL_HOT_RESET  = 16'h0096;
  localparam logic [15:0] STALL_COLD_RESET = 16'h00C8;
  localparam logic [15:0] START_THR_RESET  = 16'h000F;
  localparam logic [15:0] OVERLD_THR_RESET = 16'h0014;
  localparam logic [15:0] NOM_START_RESET  = 16'h003C;
  localparam logic [15:0] NOLOAD_THR_RESET = 16'h0002;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    ST_STOPPED  = 4'h1,
    ST_STARTING = 4'h2,
    ST_RUNNING  = 4'h4,
    ST_STALLED  = 4'h8
  } mssm_state_type;

  typedef enum logic [2:0] {
    CODE_NORMAL   = 3'h0,
    CODE_START    = 3'h1,
    CODE_DT_TRIP  = 3'h2,
    CODE_CAP_TRIP = 3'h3,
    CODE_BLOCKED  = 3'h4
  } mssm_code_type;
endpackage : mssm_pkg
`default_nettype wire

// ==== hw/mssm_tick.sv ====
// Time base that pulses once per tenth of a second
`default_nettype none
module mssm_tick #(
  parameter int CYCLES = mssm_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Tick
  output var  logic tick
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] count;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count <= '0;
      tick  <= 1'b0;
    end
    else if (count == LAST)
    begin
      count <= '0;
      tick  <= 1'b1;
    end
    else
    begin
      count <= count + W'(1);
      tick  <= 1'b0;
    end
  end
endmodule : mssm_tick
`default_nettype wire

// ==== hw/mssm_i2t.sv ====
// Squared current times time accumulator and budget compare
`default_nettype none
module mssm_i2t #(
  parameter int CUR_W = 16,
  parameter int TIM_W = 16
) (
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // Control
  input  wire logic                   clear,
  input  wire logic                   step,
  // Measurement and budget
  input  wire logic [CUR_W-1:0]       current,
  input  wire logic [CUR_W-1:0]       nom_current,
  input  wire logic [TIM_W-1:0]       allowed_time,
  // Result
  output var  logic [2*CUR_W+TIM_W-1:0] total,
  output var  logic                   over
);
  localparam int ACC_W = 2 * CUR_W + TIM_W;

  logic [2*CUR_W-1:0] square;
  logic [ACC_W-1:0]   budget;

  // Budget is nominal current squared times allowed time
  assign square = current * current;
  assign budget = ACC_W'(nom_current * nom_current) * ACC_W'(allowed_time);

  always_ff @(posedge aclk)
  begin
    if (!aresetn || clear)
      total <= '0;
    else if (step)
      total <= total + ACC_W'(square);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || clear)
      over <= 1'b0;
    else
      over <= (total > budget);
  end
endmodule : mssm_i2t
`default_nettype wire

// ==== hw/mssm_top.sv ====
// Motor start and locked rotor monitor with AXI4-Lite registers
// What this block does
// RULE1 - Supervise start by fixed maximum time or by squared-current budget.
// RULE2 - Squared-current mode grants longer start when starting current is lower.
// RULE3 - Allowed time is manual or hot/cold safe stall time by thermal state.
// RULE4 - Accumulate squared current during start; continue while within budget.
// RULE5 - Start lasting beyond permitted value asserts trip output.
// RULE6 - Enabled active speed switch lets start run past maximum start time.
// RULE7 - With speed switch, still trip once safe stall time is exceeded.
// RULE8 - After start, supervise running motor for stalled rotor.
// RULE9 - Configurer should set start limit to expected time plus ten percent.
// RULE10 - Start begins above start-detect from stopped; ends below overload threshold.
// RULE11 - Stall uses same limits and speed switch as start; trips when exceeded.
// RULE12 - Forced status overrides outputs: normal, start, time trip, capacity trip, blocked.
// RULE13 - Start timer and squared-current total clear on new start from stopped.
// RULE14 - Trip holds until starting condition ends or function is reset.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`default_nettype none
module mssm_top #(
  parameter int CUR_W       = 16,
  parameter int TICK_CYCLES = mssm_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // AXI4-Lite write address
  input  wire logic [5:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output var  logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output var  logic             s_axi_wready,
  // AXI4-Lite write response
  output var  logic [1:0]       s_axi_bresp,
  output var  logic             s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [5:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output var  logic             s_axi_arready,
  // AXI4-Lite read data
  output var  logic [31:0]      s_axi_rdata,
  output var  logic [1:0]       s_axi_rresp,
  output var  logic             s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // Motor measurements
  input  wire logic [CUR_W-1:0] phase_current,
  input  wire logic             speed_switch,
  input  wire logic             motor_hot,
  // Outputs
  output var  logic             trip,
  output var  logic             start_active,
  output var  logic [2:0]       status_code,
  output var  logic             irq
);
  // ****************************************
  // Declarations
  // ****************************************
  localparam int TIM_W = 16;

  logic [31:0]               ctrl;
  logic [TIM_W-1:0]          start_time;
  logic [TIM_W-1:0]          stall_hot;
  logic [TIM_W-1:0]          stall_cold;
  logic [CUR_W-1:0]          start_thr;
  logic [CUR_W-1:0]          overld_thr;
  logic [CUR_W-1:0]          nom_start;
  logic [CUR_W-1:0]          noload_thr;
  logic [mssm_pkg::IRQ_BITS-1:0] irq_status;
  logic [mssm_pkg::IRQ_BITS-1:0] irq_mask;
  logic [mssm_pkg::IRQ_BITS-1:0] events;
  logic                      func_reset;
  logic                      aw_full;
  logic                      w_full;
  logic [5:0]                aw_addr;
  logic [31:0]               w_data;
  logic [3:0]                w_strb;
  logic                      do_write;
  logic                      do_read;
  logic [31:0]               wr_merged;
  logic                      wr_mapped;
  logic [31:0]               rd_value;
  logic                      rd_mapped;
  mssm_pkg::mssm_state_type  state;
  mssm_pkg::mssm_state_type  next_state;
  logic                      tick;
  logic [TIM_W-1:0]          elapsed;
  logic                      restart;
  logic                      watching;
  logic [TIM_W-1:0]          safe_stall;
  logic [TIM_W-1:0]          allowed;
  logic                      i2t_over;
  logic                      limit_over;
  logic                      trip_cond;
  logic                      trip_hold;
  logic                      trip_cap;
  logic [2:0]                free_code;
  logic [2:0]                force_code;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        res[8*b +: 8] = data[8*b +: 8];
    end
    return res;
  endfunction : merge

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  assign do_write = aw_full && w_full && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full       <= 1'b0;
      aw_addr       <= '0;
      s_axi_awready <= 1'b1;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
    else if (do_write)
      aw_full <= 1'b0;
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_awready <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full       <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_wready <= 1'b1;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end
    else if (do_write)
      w_full <= 1'b0;
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_wready <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= mssm_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? mssm_pkg::RESP_OKAY : mssm_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ****************************************
  // Register file
  // ****************************************
  always_comb
  begin
    wr_merged = merge(rd_value_of(aw_addr), w_data, w_strb);
    case (aw_addr)
      mssm_pkg::OFS_CTRL, mssm_pkg::OFS_START_TIME, mssm_pkg::OFS_STALL_HOT,
      mssm_pkg::OFS_STALL_COLD, mssm_pkg::OFS_START_THR, mssm_pkg::OFS_OVERLD_THR,
      mssm_pkg::OFS_NOM_START, mssm_pkg::OFS_NOLOAD_THR, mssm_pkg::OFS_STATUS,
      mssm_pkg::OFS_ELAPSED, mssm_pkg::OFS_IRQ_STATUS, mssm_pkg::OFS_IRQ_MASK:
        wr_mapped = 1'b1;
      default:
        wr_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl       <= mssm_pkg::CTRL_RESET;
      start_time <= mssm_pkg::START_TIME_RESET;
      stall_hot  <= mssm_pkg::STALL_HOT_RESET;
      stall_cold <= mssm_pkg::STALL_COLD_RESET;
      start_thr  <= mssm_pkg::START_THR_RESET;
      overld_thr <= mssm_pkg::OVERLD_THR_RESET;
      nom_start  <= mssm_pkg::NOM_START_RESET;
      noload_thr <= mssm_pkg::NOLOAD_THR_RESET;
      irq_mask   <= '0;
      func_reset <= 1'b0;
    end
    else
    begin
      func_reset <= do_write && (aw_addr == mssm_pkg::OFS_CTRL)
                    && wr_merged[mssm_pkg::CTRL_FUNC_RESET];
      if (do_write)
      begin
        case (aw_addr)
          mssm_pkg::OFS_CTRL:       ctrl       <= {21'h0, wr_merged[10:7], 2'h0, wr_merged[4:0]};
          mssm_pkg::OFS_START_TIME: start_time <= wr_merged[TIM_W-1:0];
          mssm_pkg::OFS_STALL_HOT:  stall_hot  <= wr_merged[TIM_W-1:0];
          mssm_pkg::OFS_STALL_COLD: stall_cold <= wr_merged[TIM_W-1:0];
          mssm_pkg::OFS_START_THR:  start_thr  <= wr_merged[CUR_W-1:0];
          mssm_pkg::OFS_OVERLD_THR: overld_thr <= wr_merged[CUR_W-1:0];
          mssm_pkg::OFS_NOM_START:  nom_start  <= wr_merged[CUR_W-1:0];
          mssm_pkg::OFS_NOLOAD_THR: noload_thr <= wr_merged[CUR_W-1:0];
          mssm_pkg::OFS_IRQ_MASK:   irq_mask   <= wr_merged[mssm_pkg::IRQ_BITS-1:0];
          default:                  ;
        endcase
      end
    end
  end

  function automatic logic [31:0] rd_value_of(input logic [5:0] addr);
    case (addr)
      mssm_pkg::OFS_CTRL:       return ctrl;
      mssm_pkg::OFS_START_TIME: return 32'(start_time);
      mssm_pkg::OFS_STALL_HOT:  return 32'(stall_hot);
      mssm_pkg::OFS_STALL_COLD: return 32'(stall_cold);
      mssm_pkg::OFS_START_THR:  return 32'(start_thr);
      mssm_pkg::OFS_OVERLD_THR: return 32'(overld_thr);
      mssm_pkg::OFS_NOM_START:  return 32'(nom_start);
      mssm_pkg::OFS_NOLOAD_THR: return 32'(noload_thr);
      mssm_pkg::OFS_STATUS:     return {23'h0, trip_hold, trip_cap, 4'(state), status_code};
      mssm_pkg::OFS_ELAPSED:    return 32'(elapsed);
      mssm_pkg::OFS_IRQ_STATUS: return 32'(irq_status);
      mssm_pkg::OFS_IRQ_MASK:   return 32'(irq_mask);
      default:                  return 32'h0000_0000;
    endcase
  endfunction : rd_value_of

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  assign do_read   = s_axi_arvalid && s_axi_arready;
  assign rd_value  = rd_value_of(s_axi_araddr);
  assign rd_mapped = (s_axi_araddr <= mssm_pkg::OFS_IRQ_MASK) && (s_axi_araddr[1:0] == 2'h0);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= mssm_pkg::RESP_OKAY;
    end
    else if (do_read)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_value;
      s_axi_rresp   <= rd_mapped ? mssm_pkg::RESP_OKAY : mssm_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // ****************************************
  // Motor state tracking
  // ****************************************
  always_comb
  begin
    next_state = state;
    case (state)
      mssm_pkg::ST_STOPPED:
        if (phase_current > start_thr)
          next_state = mssm_pkg::ST_STARTING; // RULE10
      mssm_pkg::ST_STARTING:
        if (phase_current < noload_thr)
          next_state = mssm_pkg::ST_STOPPED;
        else if (phase_current < overld_thr)
          next_state = mssm_pkg::ST_RUNNING; // RULE10
      mssm_pkg::ST_RUNNING:
        if (phase_current < noload_thr)
          next_state = mssm_pkg::ST_STOPPED;
        else if (ctrl[mssm_pkg::CTRL_STALL_EN] && phase_current > overld_thr)
          next_state = mssm_pkg::ST_STALLED; // RULE8
      mssm_pkg::ST_STALLED:
        if (phase_current < noload_thr)
          next_state = mssm_pkg::ST_STOPPED;
        else if (phase_current < overld_thr || !ctrl[mssm_pkg::CTRL_STALL_EN])
          next_state = mssm_pkg::ST_RUNNING;
      default:
        next_state = mssm_pkg::ST_STOPPED;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !ctrl[mssm_pkg::CTRL_ENABLE])
      state <= mssm_pkg::ST_STOPPED;
    else
      state <= next_state;
  end

  // ****************************************
  // Start timer and squared-current budget
  // ****************************************
  assign watching = (state == mssm_pkg::ST_STARTING) || (state == mssm_pkg::ST_STALLED);
  assign restart  = (next_state == mssm_pkg::ST_STARTING && state == mssm_pkg::ST_STOPPED)
                 || (next_state == mssm_pkg::ST_STALLED && state == mssm_pkg::ST_RUNNING);
  assign safe_stall = motor_hot ? stall_hot : stall_cold; // RULE3
  assign allowed    = ctrl[mssm_pkg::CTRL_AUTO_TIME] ? safe_stall : start_time; // RULE3

  mssm_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn || restart)
      elapsed <= '0; // RULE13
    else if (watching && tick && elapsed != '1)
      elapsed <= elapsed + TIM_W'(1);
  end

  mssm_i2t #(
    .CUR_W (CUR_W),
    .TIM_W (TIM_W)
  ) u_i2t (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .clear        (restart),
    .step         (watching && tick),
    .current      (phase_current),
    .nom_current  (nom_start),
    .allowed_time (allowed),
    .total        (),
    .over         (i2t_over)
  ); // RULE2 RULE4 RULE13

  // ****************************************
  // Trip decision
  // ****************************************
  assign limit_over = ctrl[mssm_pkg::CTRL_I2T_MODE] ? i2t_over : (elapsed > allowed); // RULE1
  always_comb
  begin
    if (ctrl[mssm_pkg::CTRL_SPEED_EN] && speed_switch)
      trip_cond = elapsed > safe_stall; // RULE6 RULE7
    else
      trip_cond = limit_over; // RULE5 RULE11
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || func_reset || !watching)
    begin
      trip_hold <= 1'b0; // RULE14
      trip_cap  <= 1'b0;
    end
    else if (trip_cond && !trip_hold)
    begin
      trip_hold <= 1'b1; // RULE5
      trip_cap  <= ctrl[mssm_pkg::CTRL_I2T_MODE]
                   && !(ctrl[mssm_pkg::CTRL_SPEED_EN] && speed_switch);
    end
  end

  // ****************************************
  // Outputs and forced status
  // ****************************************
  always_comb
  begin
    if (!ctrl[mssm_pkg::CTRL_ENABLE])
      free_code = mssm_pkg::CODE_BLOCKED;
    else if (trip_hold)
      free_code = trip_cap ? mssm_pkg::CODE_CAP_TRIP : mssm_pkg::CODE_DT_TRIP;
    else if (watching)
      free_code = mssm_pkg::CODE_START;
    else
      free_code = mssm_pkg::CODE_NORMAL;
  end

  assign force_code = ctrl[mssm_pkg::CTRL_FORCE_LSB +: 3];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_code  <= mssm_pkg::CODE_NORMAL;
      trip         <= 1'b0;
      start_active <= 1'b0;
    end
    else if (ctrl[mssm_pkg::CTRL_FORCE_EN])
    begin
      status_code  <= force_code; // RULE12
      trip         <= (force_code == mssm_pkg::CODE_DT_TRIP)
                   || (force_code == mssm_pkg::CODE_CAP_TRIP);
      start_active <= (force_code == mssm_pkg::CODE_START);
    end
    else
    begin
      status_code  <= free_code;
      trip         <= trip_hold;
      start_active <= watching && ctrl[mssm_pkg::CTRL_ENABLE];
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  assign events[mssm_pkg::IRQ_START_SEEN] = state == mssm_pkg::ST_STOPPED
                                         && next_state == mssm_pkg::ST_STARTING;
  assign events[mssm_pkg::IRQ_TRIP]       = trip_cond && !trip_hold && watching;
  assign events[mssm_pkg::IRQ_STALL_SEEN] = state == mssm_pkg::ST_RUNNING
                                         && next_state == mssm_pkg::ST_STALLED;
  assign events[mssm_pkg::IRQ_START_DONE] = state == mssm_pkg::ST_STARTING
                                         && next_state == mssm_pkg::ST_RUNNING;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_status <= '0;
    else if (do_read && s_axi_araddr == mssm_pkg::OFS_IRQ_STATUS)
      irq_status <= events;
    else
      irq_status <= irq_status | events;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_status & irq_mask);
  end
endmodule : mssm_top
`default_nettype wire

// ==== dv/mssm_asserts.sv ====
// Port assertions of the start and stall monitor
`default_nettype none
module mssm_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Motor side
  input wire logic [15:0] phase_current,
  input wire logic trip,
  input wire logic start_active
);
  // ****
  // Checks
  // ****
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_dead;
    (phase_current == 16'h0) [*4];
  endsequence
  sequence s_bdone;
    s_axi_bvalid && s_axi_bready;
  endsequence
  a_reset_idle: assert property (disable iff (1'h0) !aresetn |=> !trip && !s_axi_bvalid)
    else $error("outputs busy after reset");
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write answer late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_ready_back: assert property (s_bdone |=> !s_axi_bvalid ##1 s_axi_awready && s_axi_wready)
    else $error("write ready not back");
  a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_dead_clear: assert property (s_dead |=> !trip && !start_active)
    else $error("trip kept without current");
  a_start_seen: assert property (s_dead ##1 (phase_current > 16'h0014) [*3] |=> start_active)
    else $error("start not seen");
endmodule : mssm_asserts
bind mssm_top mssm_asserts u_chk (.*);
`default_nettype wire

// ==== dv/mssm_motor.sv ====
// Behavioural motor with speed switch and breaker
`default_nettype none
module mssm_motor (
  // Clock
  input wire logic aclk,
  // Bench commands
  input wire logic [15:0] cmd_cur,
  input wire logic cmd_spd,
  input wire logic cmd_hot,
  // Breaker coil
  input wire logic trip,
  // Measurements
  output var logic [15:0] phase_current,
  output var logic speed_switch,
  output var logic motor_hot
);
  timeunit 1ns;
  timeprecision 1ps;
  int n_trip = 0;
  initial
  begin
    phase_current = 16'h0;
    speed_switch = 1'h0;
    motor_hot = 1'h0;
  end
  // Breaker opens after a slow mechanical delay, recloses once the start is removed
  always @(posedge aclk)
  begin
    n_trip <= trip ? n_trip + 1 : (cmd_cur == 16'h0 ? 0 : n_trip);
    phase_current <= n_trip >= 30 ? 16'h0 : cmd_cur;
    speed_switch <= cmd_spd;
    motor_hot <= cmd_hot;
  end
endmodule : mssm_motor
`default_nettype wire

// ==== dv/mssm_top_test.sv ====
// Self-checking bench of the motor start and stall monitor
`default_nettype none
module mssm_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'h0, aresetn = 1'h0, cmd_spd = 1'h0, cmd_hot = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, trip, start_active, irq;
  logic speed_switch, motor_hot;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, seed = 32'h029CA069;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [15:0] phase_current, cmd_cur = 16'h0;
  logic [2:0] status_code;
  logic [17:0] tab [8] = '{18'h00130, 18'h0033C, 18'h0031E, 18'h10530,
                           18'h00530, 18'h20930, 18'h10930, 18'h01130};
  logic [31:0] rv [9] = '{32'h1, 32'h96, 32'h96, 32'hC8, 32'hF, 32'h14, 32'h3C, 32'h2, 32'h0};
  int n_fail = 0, cmp_count = 0, cyc = 0;
  mssm_top #(.TICK_CYCLES(10)) dut (.*);
  mssm_motor motor (.*);
  always #4 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      $display("mismatch at %0t: run too long", $time);
      finish_test();
    end
  end
  // ****
  // Tasks
  // ****
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'h0} ^ (x[31] ? 32'h00400007 : 32'h0);
  endfunction : lfsr
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_t(input int k, lo, hi);
    cmp_count++;
    if (k < lo || k > hi)
    begin
      n_fail++;
      $display("mismatch at %0t: trip after %0d cycles", $time, k);
    end
  endtask : chk_t
  task automatic axw(input logic [5:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h1;
    @(posedge aclk);
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask : axw
  task automatic axr(input logic [5:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end
    while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h1;
    @(posedge aclk);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask : axr
  task automatic run(input logic [17:0] r);
    logic [7:0] c;
    int t, a, n, k, i;
    c = r[15:8];
    i = int'(r[7:0]);
    t = 3 + int'(seed[1:0]);
    cmd_cur <= 16'h0;
    cmd_spd <= r[17];
    cmd_hot <= r[16];
    axw(6'h04, 32'(t));
    axw(6'h08, 32'(t + 1));
    axw(6'h0C, 32'(t + 3));
    axw(6'h2C, {28'h0, {4{seed[2]}}});
    axw(6'h00, {24'h0, c});
    axr(6'h28, rd);
    a = (c[2] || (r[17] && c[3])) ? t + 1 + 2 * int'(!r[16]) : t;
    n = (c[1] && !(r[17] && c[3])) ? 3600 * a / (i * i) + 1 : a + 1;
    if (c[4])
    begin
      cmd_cur <= 16'h0030;
      repeat (6) @(posedge aclk);
      cmd_cur <= 16'h0010;
      repeat (6) @(posedge aclk);
    end
    cmd_cur <= 16'(i);
    k = 0;
    do
    begin
      @(posedge aclk);
      k++;
    end
    while (trip !== 1'h1 && k < 600);
    chk_t(k, (n - 1) * 10, n * 10 + 12);
    @(posedge aclk);
    chk(32'(status_code), (c[1] && !(r[17] && c[3])) ? 32'h3 : 32'h2);
    chk(32'(irq), 32'(seed[2]));
    axr(6'h28, rd);
    chk(rd, c[4] ? 32'hF : 32'h3);
    chk(32'(trip), 32'h1);
    seed = lfsr(seed);
  endtask : run
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // ****
  // Sequence
  // ****
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    for (int i = 0; i < 9; i++)
    begin
      axr(6'(i == 8 ? 48 : i * 4), rd);
      chk(rd, rv[i]);
      chk(32'(rs), i == 8 ? 32'h2 : 32'h0);
    end
    $display("test registers done");
    cmd_cur <= 16'h000A;
    for (int c = 0; c < 5; c++)
    begin
      axw(6'h00, 32'h81 | 32'(c << 8));
      repeat (3) @(posedge aclk);
      chk(32'(status_code), 32'(c));
      chk(32'(trip), 32'(c == 2 || c == 3));
      chk(32'(rs), 32'h0);
    end
    $display("test forcing done");
    for (int i = 0; i < 8; i++)
    begin
      run(tab[i]);
      $display("test start %0d done", i);
    end
    finish_test();
  end
endmodule : mssm_top_test
`default_nettype wire
